// File: rtl/tdas_defines.vh
`ifndef TDAS_DEFINES_VH
`define TDAS_DEFINES_VH
// register numbers
`define TDAS_REG_PRINT_LINE 4'h1
`define TDAS_REG_LINES_ABOVE 4'h3
`define TDAS_REG_SHOW_CTRL 4'h4
`define TDAS_REG_WIDTH 4'h9
// memory geometry
`define TDAS_MEM_LINES 57
`define TDAS_VIS_LINES 18
`define TDAS_MAX_ABOVE 39
`define TDAS_WIDE_COLS 80
`define TDAS_NARROW_COLS 50
// character codes
`define TDAS_ATTR_PREFIX 5'h10
`define TDAS_ATTR_UL_BIT 2
`define TDAS_ATTR_BL_BIT 1
`define TDAS_ATTR_INV_BIT 0
`define TDAS_CH_NUL 8'h00
`define TDAS_CH_BS 8'h08
`define TDAS_CH_LF 8'h0A
`define TDAS_CH_FF 8'h0C
`define TDAS_CH_CR 8'h0D
`define TDAS_CH_SPACE 8'h20
`endif

// File: rtl/tdas_attr_decode.v
`timescale 1ns/10ps
`include "tdas_defines.vh"
module tdas_attr_decode (
	// character in
	input wire [7:0] code,
	// decode out
	output wire is_attr,
	output wire [2:0] attr,
	output wire is_ctrl
);
	assign is_attr = (code[7:3] == `TDAS_ATTR_PREFIX);
	// underline bit2, blink bit1, inverse bit0
	assign attr = code[2:0];
	assign is_ctrl = (code[7:5] == 3'h0);
endmodule

// File: rtl/tdas_display.v
`timescale 1ns/10ps
`include "tdas_defines.vh"
// Function
// - codes 128 to 135 are attribute commands, top five bits 10000.
// - bit 2 underline, bit 1 blink, bit 0 inverse, any mix.
// - attribute state sticks for later characters until code 128.
// - attribute codes write nothing to the screen.
// - message line handles attributes the same as output area.
// - show mode stores control codes except null; carriage return also does CR and LF.
// - nonzero write to register 4 enables show mode; no message shown.
// - memory holds 57 lines, 18 visible, up to 39 above.
// - register 3 reads lines above window, saturating at 39.
// - addresses start at column 1 line 1; corner is 50 or 80, 18.
// - printable increments column; past width wraps to column 1, next line.
// - print line is window relative; reads 19 past the bottom.
// - character at off screen position scrolls first, then rebases lines.
// - register 9 reads screen width, 80 wide or 50 narrow.
// - line above 18 written to register 1 defers scroll up.
// - line 0 or below scrolls toward earlier lines on next output.
// - line below one minus lines above flags an error.
// - null at off screen position scrolls without writing.
// - BS back one unless column 1; LF down; CR column 1; others ignored.
// - form feed scrolls fully up, two blank lines, ends on second.
module tdas_display #(
	parameter WIDE = 1,
	parameter COLS = 80
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// character stream to output area
	input wire char_valid,
	input wire [7:0] char_data,
	output wire char_ready,
	// character stream to message line
	input wire msg_valid,
	input wire [7:0] msg_data,
	// register access
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	output reg reg_error,
	// render read port, line relative to memory top row 0
	input wire [5:0] rd_row,
	input wire [6:0] rd_col,
	output reg [10:0] rd_cell,
	output reg [10:0] msg_cell,
	// state
	output reg show_ctrl,
	output reg [2:0] cur_attr,
	output reg [2:0] msg_attr
);
	localparam ROWS = `TDAS_MEM_LINES;
	localparam VIS = `TDAS_VIS_LINES;
	localparam signed [15:0] VIS_S = `TDAS_VIS_LINES;
	localparam MAXA = `TDAS_MAX_ABOVE;
	localparam ST_IDLE = 2'h0;
	localparam ST_CLEAR = 2'h1;
	localparam ST_FF = 2'h2;
	localparam [15:0] WIDTH_VAL = WIDE ? `TDAS_WIDE_COLS : `TDAS_NARROW_COLS;
	localparam [6:0] LAST_COL = WIDTH_VAL[6:0];
	// cell = attribute over character
	reg [10:0] mem [0:ROWS*128-1];
	reg [10:0] msg_mem [0:127];
	reg [1:0] state;
	reg [5:0] above; // lines above window
	reg [5:0] used; // lines of memory in use past top
	reg signed [15:0] line; // window relative print line
	reg [6:0] col; // print column, 1 based
	reg [6:0] msg_col;
	reg [6:0] clr_col;
	reg [5:0] clr_row;
	reg [1:0] ff_left;
	wire is_attr;
	wire [2:0] attr_bits;
	wire is_ctrl;
	wire m_is_attr;
	wire [2:0] m_attr_bits;
	wire m_is_ctrl;
	wire on_screen;
	reg signed [15:0] shift;
	wire [5:0] new_above;
	wire wrap;
	wire signed [15:0] eff_line;
	wire [6:0] wr_col;
	reg [15:0] rd_next;
	tdas_attr_decode u_dec (
		.code(char_data),
		.is_attr(is_attr),
		.attr(attr_bits),
		.is_ctrl(is_ctrl)
	);
	tdas_attr_decode u_mdec (
		.code(msg_data),
		.is_attr(m_is_attr),
		.attr(m_attr_bits),
		.is_ctrl(m_is_ctrl)
	);
	function [12:0] cell_addr;
		input [5:0] r;
		input [6:0] c;
		begin
			cell_addr = {r, c};
		end
	endfunction
	function [5:0] clamp_above;
		input signed [15:0] v;
		begin
			if (v < 0) begin
				clamp_above = 6'h00;
			end else if (v > MAXA) begin
				clamp_above = MAXA[5:0];
			end else begin
				clamp_above = v[5:0];
			end
		end
	endfunction
	assign char_ready = (state == ST_IDLE);
	wire printable = !is_attr && !(is_ctrl && !show_ctrl) && (char_data != `TDAS_CH_NUL);
	// wrap is deferred: a full line keeps its print line until one more glyph comes
	assign wrap = printable && (col > LAST_COL);
	assign eff_line = wrap ? (line + 16'sd1) : line;
	assign wr_col = wrap ? 7'h01 : col;
	assign on_screen = (eff_line >= 16'sd1) && (eff_line <= VIS_S);
	// scroll amount so that the print line lands on screen
	always @* begin
		if (eff_line > VIS_S) begin
			shift = eff_line - VIS_S;
		end else if (eff_line < 16'sd1) begin
			shift = eff_line - 16'sd1;
		end else begin
			shift = 16'sd0;
		end
	end
	assign new_above = clamp_above($signed({10'h000, above}) + shift);
	wire [5:0] abs_row = above + eff_line[5:0] - 6'h01;
	wire [5:0] tgt_row = new_above + eff_line[5:0] - shift[5:0] - 6'h01;
	wire [5:0] wr_row = on_screen ? abs_row : tgt_row;
	wire [15:0] line_after = on_screen ? eff_line : (eff_line - shift);
	// read mux apart so read data leaves a flop
	always @* begin
		case (reg_addr)
			`TDAS_REG_PRINT_LINE: rd_next = line;
			`TDAS_REG_LINES_ABOVE: rd_next = {10'h000, above};
			`TDAS_REG_SHOW_CTRL: rd_next = {15'h0000, show_ctrl};
			`TDAS_REG_WIDTH: rd_next = WIDTH_VAL;
			default: rd_next = 16'h0000;
		endcase
	end
	always @(posedge clk) begin
		if (state == ST_CLEAR) begin
			mem[cell_addr(clr_row, clr_col)] <= {3'h0, `TDAS_CH_SPACE};
		end else if (char_valid && char_ready && printable) begin
			mem[cell_addr(wr_row, wr_col)] <= {cur_attr, char_data};
		end
		if (msg_valid && !m_is_attr && !m_is_ctrl) begin
			msg_mem[msg_col] <= {msg_attr, msg_data};
		end
		rd_cell <= mem[cell_addr(rd_row, rd_col)];
		msg_cell <= msg_mem[rd_col];
	end
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			above <= 6'h00;
			used <= 6'h00;
			line <= 16'sd1;
			col <= 7'h01;
			msg_col <= 7'h01;
			clr_col <= 7'h01;
			clr_row <= 6'h00;
			ff_left <= 2'h0;
			show_ctrl <= 1'b0;
			cur_attr <= 3'h0;
			msg_attr <= 3'h0;
			reg_error <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			reg_error <= 1'b0;
			if (msg_valid) begin
				if (m_is_attr) begin
					msg_attr <= m_attr_bits;
				end else if (msg_data == `TDAS_CH_CR) begin
					msg_col <= 7'h01;
				end else if (!m_is_ctrl && msg_col < LAST_COL) begin
					msg_col <= msg_col + 7'h01;
				end
			end
			if (reg_rd) begin
				reg_rdata <= rd_next;
			end
			if (reg_wr && state == ST_IDLE) begin
				case (reg_addr)
					`TDAS_REG_PRINT_LINE: begin
						if ($signed(reg_wdata) < 16'sd1 - $signed({10'h000, above})) begin
							reg_error <= 1'b1;
						end else begin
							line <= reg_wdata;
						end
					end
					`TDAS_REG_SHOW_CTRL: show_ctrl <= (reg_wdata != 16'h0000);
					default: ;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (char_valid) begin
						if (!on_screen) begin
							// scroll then rebase to the new top line
							above <= new_above;
							line <= line_after;
						end
						if (is_attr) begin
							cur_attr <= attr_bits;
						end else if (is_ctrl && !show_ctrl) begin
							case (char_data)
								`TDAS_CH_BS: if (col != 7'h01) col <= col - 7'h01;
								`TDAS_CH_LF: line <= line_after + 16'sd1;
								`TDAS_CH_CR: col <= 7'h01;
								`TDAS_CH_FF: begin
									ff_left <= 2'h2;
									state <= ST_FF;
								end
								default: ;
							endcase
						end else if (char_data == `TDAS_CH_CR) begin
							col <= 7'h01;
							line <= line_after + 16'sd1;
						end else if (char_data != `TDAS_CH_NUL) begin
							if (wrap) begin
								col <= 7'h02;
								line <= line_after;
							end else begin
								col <= col + 7'h01;
							end
						end
						if (wr_row + 6'h01 > used) begin
							used <= wr_row + 6'h01;
						end
					end
				end
				ST_FF: begin
					// blank lines become the top of the window, so print line 2 is on them
					if (ff_left == 2'h2) begin
						above <= clamp_above({10'h000, used});
						clr_row <= clamp_above({10'h000, used});
						clr_col <= 7'h01;
						ff_left <= 2'h1;
						state <= ST_CLEAR;
					end else begin
						line <= 16'sd2;
						col <= 7'h01;
						state <= ST_IDLE;
					end
				end
				ST_CLEAR: begin
					// two blank lines, one cell per clock
					if (clr_col == LAST_COL) begin
						clr_col <= 7'h01;
						clr_row <= clr_row + 6'h01;
						if (ff_left == 2'h0) begin
							used <= clr_row + 6'h01;
							state <= ST_FF;
						end else begin
							ff_left <= 2'h0;
						end
					end else begin
						clr_col <= clr_col + 7'h01;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

// File: testbench/tdas_display_properties.sv
`timescale 1ns/10ps
module tdas_display_chk #(
	parameter WIDE = 1
) (
	// clock and reset
	input wire clk, resetn,
	// streams
	input wire char_valid, char_ready, msg_valid,
	input wire [7:0] char_data, msg_data,
	// registers
	input wire reg_wr, reg_rd, reg_error,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata, reg_rdata,
	// state
	input wire show_ctrl,
	input wire [2:0] cur_attr, msg_attr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire take = char_valid && char_ready;
	wire is_at = char_data[7:3] == 5'h10;
	// writes are dropped while the form feed clear runs
	wire wr4 = reg_wr && char_ready && reg_addr == 4'h4;
	property p_set; take && is_at |=> cur_attr == $past(char_data[2:0]); endproperty
	a_set: assert property (p_set) else $error("attribute not taken");
	property p_hold; take && !is_at |=> $stable(cur_attr); endproperty
	a_hold: assert property (p_hold) else $error("attribute lost");
	property p_msg; msg_valid && msg_data[7:3] == 5'h10 |=> msg_attr == $past(msg_data[2:0]);
	endproperty
	a_msg: assert property (p_msg) else $error("message attribute wrong");
	property p_on; wr4 && reg_wdata != 16'h0000 |=> show_ctrl; endproperty
	a_on: assert property (p_on) else $error("show mode not set");
	property p_off; wr4 && reg_wdata == 16'h0000 |=> !show_ctrl; endproperty
	a_off: assert property (p_off) else $error("show mode not cleared");
	property p_wid;
		reg_rd && reg_addr == 4'h9 |=> reg_rdata == (WIDE != 0 ? 16'h0050 : 16'h0032);
	endproperty
	a_wid: assert property (p_wid) else $error("width wrong");
	property p_abv; reg_rd && reg_addr == 4'h3 |=> reg_rdata <= 16'h0027; endproperty
	a_abv: assert property (p_abv) else $error("lines above too big");
	property p_err; reg_error |-> $past(reg_wr && reg_addr == 4'h1); endproperty
	a_err: assert property (p_err) else $error("error without line write");
	c_attr: cover property (take && is_at);
	c_ff: cover property (take && char_data == 8'h0C);
	c_err: cover property (reg_error);
endmodule
bind tdas_display tdas_display_chk #(.WIDE(WIDE)) tdas_display_chk_inst (.*);

// File: testbench/tdas_host.sv
`timescale 1ns/10ps
module tdas_host (
	// from device
	input wire clk, char_ready, reg_error,
	// streams
	output reg char_valid, msg_valid,
	output reg [7:0] char_data, msg_data,
	// registers
	output reg reg_wr, reg_rd,
	output reg [3:0] reg_addr,
	output reg [15:0] reg_wdata,
	// render port, driven from the top-level test for cell checks
	output reg [5:0] rd_row,
	output reg [6:0] rd_col
);
	reg err;
	initial begin
		{char_valid, msg_valid, char_data, msg_data, reg_wr, reg_rd} = 20'h00000;
		{reg_addr, reg_wdata, rd_row, rd_col, err} = 34'h000000000;
	end
	// idle cycle after each unit so valid never flips twice in one step
	task put(input [7:0] c);
		begin
			char_data = c;
			char_valid = 1'b1;
			@(negedge clk);
			while (char_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
			#1 char_valid = 1'b0;
			@(posedge clk);
			#1;
		end
	endtask
	// line values stay legal unless a refusal is wanted
	task acc(input w, input [3:0] a, input [15:0] d);
		begin
			reg_wr = w;
			reg_rd = ~w;
			reg_addr = a;
			reg_wdata = d;
			@(posedge clk);
			#1 reg_wr = 1'b0;
			reg_rd = 1'b0;
			err = reg_error;
			@(posedge clk);
			#1;
		end
	endtask
	task msg(input [7:0] c);
		begin
			msg_data = c;
			msg_valid = 1'b1;
			@(posedge clk);
			#1 msg_valid = 1'b0;
			@(posedge clk);
			#1;
		end
	endtask
endmodule

// File: testbench/tdas_display_tb_top.sv
`timescale 1ns/10ps
module tdas_display_tb_top;
	reg clk = 1'b0;
	reg resetn = 1'b0;
	wire char_valid, char_ready, msg_valid, reg_wr, reg_rd, reg_error, show_ctrl;
	wire [7:0] char_data, msg_data;
	wire [3:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	wire [5:0] rd_row;
	wire [6:0] rd_col;
	wire [10:0] rd_cell, msg_cell;
	wire [2:0] cur_attr, msg_attr;
	integer n_errors = 0;
	integer tests_run = 0;
	integer i;
	always #50 clk = ~clk;
	tdas_display tdas_display_inst (.*);
	tdas_host tdas_host_inst (.*);
	task chk(input string nm, input [15:0] s, input [15:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				n_errors = n_errors + 1;
				$display("Error %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	task p(input [7:0] c); tdas_host_inst.put(c); endtask
	task w(input [3:0] a, input [15:0] d); tdas_host_inst.acc(1'b1, a, d); endtask
	task rc(input string nm, input [3:0] a, input [15:0] e);
		begin
			tdas_host_inst.acc(1'b0, a, 16'h0000);
			chk(nm, reg_rdata, e);
		end
	endtask
	task t_attr;
		begin
			rc("width", 4'h9, 16'h0050);
			rc("above", 4'h3, 16'h0000);
			for (i = 128; i < 136; i = i + 1) begin
				p(i[7:0]);
				chk("attr", cur_attr, i[2:0]);
			end
			// eight codes then a full row: codes take no column
			for (i = 0; i < 80; i = i + 1) p(8'h41);
			chk("sticky", cur_attr, 16'h0007);
			rc("line", 4'h1, 16'h0001);
			p(8'h41);
			rc("wrap", 4'h1, 16'h0002);
			tdas_host_inst.rd_col = 7'h01;
			@(posedge clk);
			#1 chk("cell", rd_cell, 16'h0741);
			tdas_host_inst.rd_row = 6'h01;
			@(posedge clk);
			#1 chk("wrapcell", rd_cell, 16'h0741);
			tdas_host_inst.rd_row = 6'h00;
			p(8'h80);
			chk("clear", cur_attr, 16'h0000);
			$display("test attr done");
		end
	endtask
	task t_ctrl;
		begin
			p(8'h0D);
			p(8'h0A);
			rc("lf", 4'h1, 16'h0003);
			w(4'h4, 16'h0001);
			chk("show", show_ctrl, 16'h0001);
			p(8'h0A);
			rc("shown", 4'h1, 16'h0003);
			p(8'h0D);
			rc("crlf", 4'h1, 16'h0004);
			w(4'h4, 16'h0000);
			chk("show", show_ctrl, 16'h0000);
			p(8'h0A);
			rc("lf", 4'h1, 16'h0005);
			$display("test ctrl done");
		end
	endtask
	task t_scroll;
		begin
			w(4'h1, 16'h0016);
			p(8'h00);
			rc("up", 4'h3, 16'h0004);
			rc("rebase", 4'h1, 16'h0012);
			w(4'h1, 16'h0000);
			p(8'h00);
			rc("down", 4'h3, 16'h0003);
			w(4'h1, 16'hFFFB);
			chk("err", tdas_host_inst.err, 16'h0001);
			rc("kept", 4'h1, 16'h0001);
			for (i = 0; i < 60; i = i + 1) begin
				p(8'h41);
				p(8'h0D);
				p(8'h0A);
			end
			rc("sat", 4'h3, 16'h0027);
			rc("bottom", 4'h1, 16'h0013);
			p(8'h0C);
			p(8'h00);
			rc("ff", 4'h1, 16'h0002);
			rc("ffabove", 4'h3, 16'h0027);
			$display("test scroll done");
		end
	endtask
	task t_msg;
		begin
			tdas_host_inst.msg(8'h85);
			chk("msg", msg_attr, 16'h0005);
			tdas_host_inst.msg(8'h41);
			chk("msg", msg_attr, 16'h0005);
			chk("mcell", msg_cell, 16'h0541);
			tdas_host_inst.msg(8'h80);
			chk("msg", msg_attr, 16'h0000);
			$display("test msg done");
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 resetn = 1'b1;
		t_attr;
		t_ctrl;
		t_scroll;
		t_msg;
		finish_test;
	end
	// run needs under a thousand cycles; fifty thousand is a hang
	initial begin
		#5000000;
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule
